// ==== logic/rscl_params.svh ====
`ifndef RSCL_PARAMS_SVH
`define RSCL_PARAMS_SVH

// Register offsets on the plain register port
`define RSCL_OFS_MS_HI 8'h00
`define RSCL_OFS_MS_LO 8'h04
`define RSCL_OFS_ROMDAC 8'h08
`define RSCL_OFS_SWITCH 8'h0C
`define RSCL_OFS_STATUS 8'h10
`define RSCL_OFS_CTRL 8'h14

// Control and status bit positions
`define RSCL_CTRL_RELATCH 0
`define RSCL_STAT_VALID 0
`define RSCL_STAT_ORG_RSVD 1
`define RSCL_STAT_WID_RSVD 2

// Memory data strap positions
`define RSCL_MS_HI_MSB 29
`define RSCL_MS_HI_LSB 16
`define RSCL_MS_LIN_MSB 27
`define RSCL_MS_LIN_LSB 24
`define RSCL_MS_TRUECOLOR 23
`define RSCL_MS_ORG_MSB 19
`define RSCL_MS_ORG_LSB 18
`define RSCL_MS_ADDRSEL 17
`define RSCL_MS_ISA16 16
`define RSCL_MS_BIOS16 7
`define RSCL_MS_ROMEN 6
`define RSCL_MS_IO3XX 5
`define RSCL_MS_ISA 4
`define RSCL_MS_SW_MSB 3
`define RSCL_MS_SW_LSB 0

// ROM/DAC strap positions
`define RSCL_RS_VMEM16 7
`define RSCL_RS_WID_MSB 6
`define RSCL_RS_WID_LSB 5
`define RSCL_RS_PORT3C3 4
`define RSCL_RS_BIOS32K 3
`define RSCL_RS_BIOSWAIT 1
`define RSCL_RS_FASTDEC 0

// Reset values
`define RSCL_RST_MS_HI 14'h0000
`define RSCL_RST_BYTE 8'h00
`define RSCL_RST_NIBBLE 4'h0
`define RSCL_RST_DATA 16'h0000

`endif

// ==== logic/rscl_pkg.sv ====
package rscl_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_IN_RESET = 2'h1,
        ST_CONFIGURED = 2'h3
    } rscl_state_e;

    typedef enum logic [1:0] {
        ORG_256KX16 = 2'h0,
        ORG_512KX8 = 2'h1,
        ORG_RESERVED = 2'h2,
        ORG_256KX4_1MB = 2'h3
    } rscl_dram_org_e;

    typedef enum logic [1:0] {
        WID_RESERVED = 2'h0,
        WID_8 = 2'h1,
        WID_16 = 2'h2,
        WID_32 = 2'h3
    } rscl_dram_width_e;

endpackage : rscl_pkg

// ==== logic/rscl_strap_decode.sv ====
`timescale 1ns/1ps
`include "rscl_params.svh"

// Maps raw strap levels to configuration fields
module rscl_strap_decode (
    input wire logic [31:0] mem_i,
    input wire logic [7:0] rom_i,
    output logic [3:0] linear_base_o,
    output logic true_color_en_o,
    output rscl_pkg::rscl_dram_org_e dram_org_o,
    output rscl_pkg::rscl_dram_width_e dram_width_o,
    output logic latched_addr_sel_o,
    output logic isa_16bit_o,
    output logic bios_16bit_o,
    output logic rom_enable_o,
    output logic io_at_3xx_o,
    output logic isa_bus_o,
    output logic [3:0] switch_o,
    output logic vmem_16bit_o,
    output logic port_ctrl_3c3_o,
    output logic bios_32k_o,
    output logic bios_wait_ext_o,
    output logic fast_addr_detect_o
);

    always_comb begin
        linear_base_o = mem_i[`RSCL_MS_LIN_MSB:`RSCL_MS_LIN_LSB];
        true_color_en_o = ~mem_i[`RSCL_MS_TRUECOLOR];
        dram_org_o = rscl_pkg::rscl_dram_org_e'(mem_i[`RSCL_MS_ORG_MSB:`RSCL_MS_ORG_LSB]);
        latched_addr_sel_o = mem_i[`RSCL_MS_ADDRSEL];
        isa_16bit_o = mem_i[`RSCL_MS_ISA16];
        bios_16bit_o = mem_i[`RSCL_MS_BIOS16];
        rom_enable_o = mem_i[`RSCL_MS_ROMEN];
        io_at_3xx_o = mem_i[`RSCL_MS_IO3XX];
        isa_bus_o = mem_i[`RSCL_MS_ISA];
        switch_o = mem_i[`RSCL_MS_SW_MSB:`RSCL_MS_SW_LSB];
        vmem_16bit_o = rom_i[`RSCL_RS_VMEM16];
        dram_width_o = rscl_pkg::rscl_dram_width_e'(rom_i[`RSCL_RS_WID_MSB:`RSCL_RS_WID_LSB]);
        port_ctrl_3c3_o = rom_i[`RSCL_RS_PORT3C3];
        bios_32k_o = rom_i[`RSCL_RS_BIOS32K];
        bios_wait_ext_o = rom_i[`RSCL_RS_BIOSWAIT];
        fast_addr_detect_o = rom_i[`RSCL_RS_FASTDEC];
    end

endmodule : rscl_strap_decode

// ==== logic/rscl_top.sv ====
`timescale 1ns/1ps
`include "rscl_params.svh"

// Notes on behaviour
// - Memory data straps 27..24 give the linear window base address.
// - Strap 23 low enables true colour; high leaves it disabled.
// - DRAM organisation strap picks memory type and shared pin use.
// - Four lowest memory data straps readable as 4-bit switch settings.
// - ROM/DAC straps 6..5 pick DRAM data width 8, 16 or 32.
// - ROM/DAC strap 4 picks port control at 46E8 (low) or 3C3.
// - ROM/DAC strap 1 picks standard or extended BIOS wait states.
// - ROM/DAC strap 0 picks slow or fast host address detection.
// - With 512Kx8 memory the shared pin drives the extra address bit.
// - Strap 7 sizes BIOS accesses: high 16-bit, low 8-bit.
// - Strap 6 low at reset keeps the BIOS ROM disabled.
// - Strap 4 picks host bus: low alternative channel, high ISA.
module rscl_top (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic sys_reset_i,
    input wire logic [31:0] mem_strap_i,
    input wire logic [7:0] rom_strap_i,
    input wire logic mem_addr9_i,
    input wire logic nmi_req_i,
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    output logic cfg_valid_o,
    output logic [3:0] linear_base_o,
    output logic true_color_en_o,
    output logic [1:0] dram_org_o,
    output logic [1:0] dram_width_o,
    output logic shared_pin_o,
    output logic shared_pin_oe_o,
    output logic latched_addr_sel_o,
    output logic isa_16bit_o,
    output logic bios_16bit_o,
    output logic rom_enable_o,
    output logic io_at_3xx_o,
    output logic isa_bus_o,
    output logic [3:0] switch_o,
    output logic vmem_16bit_o,
    output logic port_ctrl_3c3_o,
    output logic bios_32k_o,
    output logic bios_wait_ext_o,
    output logic fast_addr_detect_o
);

    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
        is_reg = (a == ofs);
    endfunction : is_reg

    rscl_pkg::rscl_state_e state_r, state_nxt;
    logic cfg_valid_r, cfg_valid_nxt;
    logic [13:0] ms_hi_r, ms_hi_nxt;
    logic [7:0] ms_lo_r, ms_lo_nxt;
    logic [7:0] rs_r, rs_nxt;
    logic [3:0] lin_r, lin_nxt;
    logic tc_r, tc_nxt;
    rscl_pkg::rscl_dram_org_e org_r, org_nxt;
    rscl_pkg::rscl_dram_width_e wid_r, wid_nxt;
    logic [12:0] flags_r, flags_nxt;
    logic [3:0] sw_r, sw_nxt;
    logic shp_r, shp_nxt;
    logic shp_oe_r, shp_oe_nxt;
    logic [15:0] rdata_r, rdata_nxt;

    logic [3:0] d_lin;
    logic d_tc;
    rscl_pkg::rscl_dram_org_e d_org;
    rscl_pkg::rscl_dram_width_e d_wid;
    logic [12:0] d_flags;
    logic [3:0] d_sw;
    logic capture;
    logic relatch;

    rscl_strap_decode u_decode (
        .mem_i(mem_strap_i),
        .rom_i(rom_strap_i),
        .linear_base_o(d_lin),
        .true_color_en_o(d_tc),
        .dram_org_o(d_org),
        .dram_width_o(d_wid),
        .latched_addr_sel_o(d_flags[0]),
        .isa_16bit_o(d_flags[1]),
        .bios_16bit_o(d_flags[2]),
        .rom_enable_o(d_flags[3]),
        .io_at_3xx_o(d_flags[4]),
        .isa_bus_o(d_flags[5]),
        .switch_o(d_sw),
        .vmem_16bit_o(d_flags[6]),
        .port_ctrl_3c3_o(d_flags[7]),
        .bios_32k_o(d_flags[8]),
        .bios_wait_ext_o(d_flags[9]),
        .fast_addr_detect_o(d_flags[10])
    );
    assign d_flags[12:11] = 2'h0;

    // Software relatch only while reset is gone and a set is held
    assign relatch = wr_i && is_reg(addr_i, `RSCL_OFS_CTRL) && wdata_i[`RSCL_CTRL_RELATCH]
        && !sys_reset_i && (state_r == rscl_pkg::ST_CONFIGURED);
    assign capture = ce_i && (((state_r == rscl_pkg::ST_IN_RESET) && !sys_reset_i) || relatch);

    always_comb begin
        state_nxt = state_r;
        cfg_valid_nxt = cfg_valid_r;
        ms_hi_nxt = ms_hi_r;
        ms_lo_nxt = ms_lo_r;
        rs_nxt = rs_r;
        lin_nxt = lin_r;
        tc_nxt = tc_r;
        org_nxt = org_r;
        wid_nxt = wid_r;
        flags_nxt = flags_r;
        sw_nxt = sw_r;
        if (sys_reset_i) begin
            state_nxt = rscl_pkg::ST_IN_RESET;
        end else if (state_r == rscl_pkg::ST_IN_RESET) begin
            state_nxt = rscl_pkg::ST_CONFIGURED;
        end
        if (capture) begin
            cfg_valid_nxt = 1'b1;
            ms_hi_nxt = mem_strap_i[`RSCL_MS_HI_MSB:`RSCL_MS_HI_LSB];
            ms_lo_nxt = mem_strap_i[7:0];
            rs_nxt = rom_strap_i;
            lin_nxt = d_lin;
            tc_nxt = d_tc;
            org_nxt = d_org;
            wid_nxt = d_wid;
            flags_nxt = d_flags;
            sw_nxt = d_sw;
        end
    end

    // Shared pin follows the captured organisation
    always_comb begin
        shp_nxt = 1'b0;
        shp_oe_nxt = 1'b0;
        if (cfg_valid_r) begin
            case (org_r)
                rscl_pkg::ORG_512KX8: begin
                    shp_nxt = mem_addr9_i;
                    shp_oe_nxt = 1'b1;
                end
                rscl_pkg::ORG_256KX4_1MB: begin
                    shp_nxt = nmi_req_i;
                    shp_oe_nxt = 1'b1;
                end
                default: begin
                    shp_nxt = 1'b0;
                    shp_oe_nxt = 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        rdata_nxt = `RSCL_RST_DATA;
        if (rd_i) begin
            if (is_reg(addr_i, `RSCL_OFS_MS_HI)) begin
                rdata_nxt = {2'h0, ms_hi_r};
            end else if (is_reg(addr_i, `RSCL_OFS_MS_LO)) begin
                rdata_nxt = {8'h00, ms_lo_r};
            end else if (is_reg(addr_i, `RSCL_OFS_ROMDAC)) begin
                rdata_nxt = {8'h00, rs_r};
            end else if (is_reg(addr_i, `RSCL_OFS_SWITCH)) begin
                rdata_nxt = {12'h000, sw_r};
            end else if (is_reg(addr_i, `RSCL_OFS_STATUS)) begin
                rdata_nxt = {13'h0000, (wid_r == rscl_pkg::WID_RESERVED),
                    (org_r == rscl_pkg::ORG_RESERVED), cfg_valid_r};
            end else begin
                rdata_nxt = `RSCL_RST_DATA;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state_r <= rscl_pkg::ST_IDLE;
            cfg_valid_r <= 1'b0;
            ms_hi_r <= `RSCL_RST_MS_HI;
            ms_lo_r <= `RSCL_RST_BYTE;
            rs_r <= `RSCL_RST_BYTE;
            lin_r <= `RSCL_RST_NIBBLE;
            tc_r <= 1'b0;
            org_r <= rscl_pkg::ORG_256KX16;
            wid_r <= rscl_pkg::WID_RESERVED;
            flags_r <= 13'h0000;
            sw_r <= `RSCL_RST_NIBBLE;
            shp_r <= 1'b0;
            shp_oe_r <= 1'b0;
            rdata_r <= `RSCL_RST_DATA;
        end else if (ce_i) begin
            state_r <= state_nxt;
            cfg_valid_r <= cfg_valid_nxt;
            ms_hi_r <= ms_hi_nxt;
            ms_lo_r <= ms_lo_nxt;
            rs_r <= rs_nxt;
            lin_r <= lin_nxt;
            tc_r <= tc_nxt;
            org_r <= org_nxt;
            wid_r <= wid_nxt;
            flags_r <= flags_nxt;
            sw_r <= sw_nxt;
            shp_r <= shp_nxt;
            shp_oe_r <= shp_oe_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata_o = rdata_r;
    assign cfg_valid_o = cfg_valid_r;
    assign linear_base_o = lin_r;
    assign true_color_en_o = tc_r;
    assign dram_org_o = org_r;
    assign dram_width_o = wid_r;
    assign shared_pin_o = shp_r;
    assign shared_pin_oe_o = shp_oe_r;
    assign latched_addr_sel_o = flags_r[0];
    assign isa_16bit_o = flags_r[1];
    assign bios_16bit_o = flags_r[2];
    assign rom_enable_o = flags_r[3];
    assign io_at_3xx_o = flags_r[4];
    assign isa_bus_o = flags_r[5];
    assign switch_o = sw_r;
    assign vmem_16bit_o = flags_r[6];
    assign port_ctrl_3c3_o = flags_r[7];
    assign bios_32k_o = flags_r[8];
    assign bios_wait_ext_o = flags_r[9];
    assign fast_addr_detect_o = flags_r[10];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    sequence fall_s;
        ce_i && (state_r == rscl_pkg::ST_IN_RESET) && !sys_reset_i;
    endsequence

    capture_fall_a: assert property (fall_s |=> cfg_valid_o &&
        ms_hi_r == $past(mem_strap_i[29:16]) && rs_r == $past(rom_strap_i))
        else $error("straps not captured on reset fall");
    no_capture_a: assert property (!capture && ce_i |=> $stable(ms_lo_r) && $stable(rs_r))
        else $error("strap copy changed without capture");
    linear_base_a: assert property (capture |=> linear_base_o == $past(mem_strap_i[27:24]))
        else $error("linear base wrong");
    true_color_a: assert property (capture |=> true_color_en_o == !$past(mem_strap_i[23]))
        else $error("true colour polarity wrong");
    org_pin_a: assert property (ce_i && cfg_valid_o && dram_org_o == 2'h0 && !capture
        |=> !shared_pin_oe_o)
        else $error("shared pin driven when unused");
    switch_read_a: assert property (rd_i && ce_i && addr_i == 8'h0C |=>
        rdata_o == {12'h000, $past(sw_r)})
        else $error("switch readback wrong");
    dram_width_a: assert property (capture |=> dram_width_o == $past(rom_strap_i[6:5]))
        else $error("dram width wrong");
    port_ctrl_a: assert property (capture |=> port_ctrl_3c3_o == $past(rom_strap_i[4]))
        else $error("port control select wrong");
    bios_wait_a: assert property (capture |=> bios_wait_ext_o == $past(rom_strap_i[1]))
        else $error("bios wait select wrong");
    addr_detect_a: assert property (capture |=> fast_addr_detect_o == $past(rom_strap_i[0]))
        else $error("address detect select wrong");
    extra_addr_a: assert property (ce_i && cfg_valid_o && dram_org_o == 2'h1 && !capture
        |=> shared_pin_oe_o && shared_pin_o == $past(mem_addr9_i))
        else $error("shared pin not carrying extra address bit");
    bios_width_a: assert property (capture |=> bios_16bit_o == $past(mem_strap_i[7]))
        else $error("bios width wrong");
    rom_off_a: assert property (capture && !mem_strap_i[6] |=> !rom_enable_o)
        else $error("rom enabled despite low strap");
    bus_type_a: assert property (capture |=> isa_bus_o == $past(mem_strap_i[4]))
        else $error("bus type wrong");
    isa_cfg_a: assert property (capture |=> isa_16bit_o == $past(mem_strap_i[16]) &&
        latched_addr_sel_o == $past(mem_strap_i[17]))
        else $error("isa width or address select wrong");
    io_vmem_a: assert property (capture |=> io_at_3xx_o == $past(mem_strap_i[5]) &&
        vmem_16bit_o == $past(rom_strap_i[7]))
        else $error("io range or video memory width wrong");

    fall_c: cover property (sys_reset_i ##1 fall_s ##1 cfg_valid_o);
    relatch_c: cover property (ce_i && relatch ##1 cfg_valid_o);
    nmi_c: cover property (shared_pin_oe_o && dram_org_o == 2'h3);
    read_c: cover property (rd_i ##1 rdata_o != 16'h0000);

endmodule : rscl_top

// ==== tb/rscl_strap_board.sv ====
`timescale 1ns/1ps

// Board straps: levels held while system reset is high and one clock after, data traffic after that
module rscl_strap_board (
    input wire logic clk_i,
    input wire logic sys_reset_i,
    input wire logic [31:0] mem_level_i,
    input wire logic [7:0] rom_level_i,
    output logic [31:0] mem_o,
    output logic [7:0] rom_o
);
    logic sys_q_r;

    initial begin
        mem_o = 32'hFFFFFFFF;
        rom_o = 8'hFF;
        sys_q_r = 1'b0;
    end

    // Straps held through the capturing edge, toggling bus traffic afterwards
    always @(posedge clk_i) begin
        sys_q_r <= sys_reset_i;
        if (sys_reset_i || sys_q_r) begin
            mem_o <= mem_level_i;
            rom_o <= rom_level_i;
        end else begin
            mem_o <= ~mem_o;
            rom_o <= ~rom_o;
        end
    end
endmodule : rscl_strap_board

// ==== tb/tb_reset_strap_config_latch.sv ====
`timescale 1ns/1ps
`include "rscl_params.svh"

`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin $display("wrong value %s exp %h got %h", n, e, g); fails++; end end

module tb_reset_strap_config_latch;
    logic clk_i = 1'b0, rstn_i = 1'b0, ce_i = 1'b1, sys_reset_i = 1'b0;
    logic mem_addr9_i = 1'b0, nmi_req_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic [7:0] addr_i = 8'h00, rom_lv = 8'hFF, sr, r;
    logic [15:0] wdata_i = 16'h0000, rdata_o, dat;
    logic [31:0] mem_lv = 32'hFFFFFFFF, sm, m, seed = 32'hCB4EDA50;
    wire [31:0] mem_w;
    wire [7:0] rom_w;
    logic cfg_valid_o, true_color_en_o, shared_pin_o, shared_pin_oe_o, latched_addr_sel_o;
    logic isa_16bit_o, bios_16bit_o, rom_enable_o, io_at_3xx_o, isa_bus_o, vmem_16bit_o;
    logic port_ctrl_3c3_o, bios_32k_o, bios_wait_ext_o, fast_addr_detect_o;
    logic [3:0] linear_base_o, switch_o;
    logic [1:0] dram_org_o, dram_width_o;
    logic [23:0] cfg_w;
    int fails = 0, check_count = 0;

    always #25 clk_i = ~clk_i;

    rscl_strap_board rscl_strap_board_i (.clk_i(clk_i), .sys_reset_i(sys_reset_i),
        .mem_level_i(mem_lv), .rom_level_i(rom_lv), .mem_o(mem_w), .rom_o(rom_w));

    rscl_top rscl_top_i (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
        .sys_reset_i(sys_reset_i), .mem_strap_i(mem_w), .rom_strap_i(rom_w),
        .mem_addr9_i(mem_addr9_i), .nmi_req_i(nmi_req_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .cfg_valid_o(cfg_valid_o), .linear_base_o(linear_base_o),
        .true_color_en_o(true_color_en_o), .dram_org_o(dram_org_o),
        .dram_width_o(dram_width_o), .shared_pin_o(shared_pin_o),
        .shared_pin_oe_o(shared_pin_oe_o), .latched_addr_sel_o(latched_addr_sel_o),
        .isa_16bit_o(isa_16bit_o), .bios_16bit_o(bios_16bit_o),
        .rom_enable_o(rom_enable_o), .io_at_3xx_o(io_at_3xx_o), .isa_bus_o(isa_bus_o),
        .switch_o(switch_o), .vmem_16bit_o(vmem_16bit_o),
        .port_ctrl_3c3_o(port_ctrl_3c3_o), .bios_32k_o(bios_32k_o),
        .bios_wait_ext_o(bios_wait_ext_o), .fast_addr_detect_o(fast_addr_detect_o));

    assign cfg_w = {linear_base_o, true_color_en_o, dram_org_o, dram_width_o,
        latched_addr_sel_o, isa_16bit_o, bios_16bit_o, rom_enable_o, io_at_3xx_o,
        isa_bus_o, switch_o, vmem_16bit_o, port_ctrl_3c3_o, bios_32k_o,
        bios_wait_ext_o, fast_addr_detect_o};

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [23:0] exp_cfg(input logic [31:0] a, input logic [7:0] b);
        return {a[27:24], ~a[23], a[19:18], b[6:5], a[17], a[16], a[7], a[6], a[5], a[4],
            a[3:0], b[7], b[4], b[3], b[1], b[0]};
    endfunction : exp_cfg

    function automatic logic [1:0] exp_pin(input logic [1:0] org, input logic a9,
        input logic nmi);
        if (org == 2'h1) return {a9, 1'b1};
        if (org == 2'h3) return {nmi, 1'b1};
        return 2'h0;
    endfunction : exp_pin

    task automatic end_of_test();
        if (fails == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        d = rdata_o;
    endtask : reg_rd

    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(negedge clk_i);
        sm = mem_w;
        sr = rom_w;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(negedge clk_i);
    endtask : reg_wr

    task automatic capture(input logic [31:0] a, input logic [7:0] b);
        @(posedge clk_i);
        mem_lv <= a;
        rom_lv <= b;
        sys_reset_i <= 1'b1;
        @(posedge clk_i);
        sys_reset_i <= 1'b0;
        @(posedge clk_i);
        @(negedge clk_i);
    endtask : capture

    task automatic check_regs(input logic [31:0] a, input logic [7:0] b);
        reg_rd(`RSCL_OFS_MS_HI, dat);
        `CHK("mem_hi", {2'h0, a[29:16]}, dat)
        reg_rd(`RSCL_OFS_MS_LO, dat);
        `CHK("mem_lo", {8'h00, a[7:0]}, dat)
        reg_rd(`RSCL_OFS_ROMDAC, dat);
        `CHK("romdac", {8'h00, b}, dat)
        reg_rd(`RSCL_OFS_SWITCH, dat);
        `CHK("switch", {12'h000, a[3:0]}, dat)
        reg_rd(`RSCL_OFS_STATUS, dat);
        `CHK("status", {13'h0000, b[6:5] == 2'h0, a[19:18] == 2'h2, 1'b1}, dat)
        reg_rd(8'hFC, dat);
        `CHK("unmapped", 16'h0000, dat)
        @(negedge clk_i);
        `CHK("rdata_idle", 16'h0000, rdata_o)
    endtask : check_regs

    initial begin
        #(20000 * 50);
        fails++;
        end_of_test();
    end

    initial begin
        repeat (16) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(negedge clk_i);
        `CHK("cfg_reset", 24'h000000, cfg_w)
        `CHK("valid_reset", 1'b0, cfg_valid_o)
        // Relatch refused before the first capture
        reg_wr(`RSCL_OFS_CTRL, 16'h0001);
        `CHK("valid_early", 1'b0, cfg_valid_o)
        `CHK("pin_oe_early", 1'b0, shared_pin_oe_o)
        for (int i = 0; i < 40; i++) begin
            m = rnd();
            r = rnd();
            if (i < 4) begin
                m[19:18] = i[1:0];
                r[6:5] = i[1:0];
            end
            if (i == 4) m = 32'hFFFFFFFF;
            if (i == 5) m = 32'h00000000;
            capture(m, r);
            `CHK("valid", 1'b1, cfg_valid_o)
            `CHK("cfg", exp_cfg(m, r), cfg_w)
            @(posedge clk_i);
            mem_addr9_i <= rnd() & 32'h1;
            nmi_req_i <= rnd() & 32'h1;
            repeat (2) @(posedge clk_i);
            @(negedge clk_i);
            `CHK("shared_pin", exp_pin(m[19:18], mem_addr9_i, nmi_req_i), {shared_pin_o, shared_pin_oe_o})
            if (i < 8) check_regs(m, r);
        end
        // Two writes that must not relatch, then a CTRL write of 1 that must
        reg_wr(`RSCL_OFS_SWITCH, 16'h0001);
        `CHK("wr_other", exp_cfg(m, r), cfg_w)
        reg_wr(`RSCL_OFS_CTRL, 16'h0000);
        `CHK("wr_ctrl0", exp_cfg(m, r), cfg_w)
        reg_wr(`RSCL_OFS_CTRL, 16'h0001);
        `CHK("relatch", exp_cfg(sm, sr), cfg_w)
        m = sm;
        r = sr;
        // Frozen clock enable hides a system reset pulse
        @(posedge clk_i);
        ce_i <= 1'b0;
        mem_lv <= ~m;
        sys_reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_reset_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        ce_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        `CHK("ce_frozen", exp_cfg(m, r), cfg_w)
        end_of_test();
    end
endmodule : tb_reset_strap_config_latch
